// File: include/cgs_pkg.sv
// Purpose: shared constants for the clock-generator two-wire config link
// Assumes: 50 MHz mclk on both ends
// Notes: register bitmap below is the block's own layout
package cgs_pkg;
   // bus address of the configuration slave
   localparam logic [6:0] CGS_BUS_ADDR = 7'h69;
   localparam int CGS_NREG = 256;
   // register map of the slave
   localparam logic [7:0] CGS_REG_OE_SENS = 8'h00;
   localparam logic [7:0] CGS_REG_MODE = 8'h01;
   localparam logic [7:0] CGS_REG_DRIVE_LO = 8'h02;
   localparam logic [7:0] CGS_REG_DRIVE_HI = 8'h03;
   localparam int CGS_MODE_KEEPALIVE_BIT = 0;
   localparam int CGS_MODE_OE_BIT = 1;
   // reset values
   localparam logic [7:0] CGS_RST_OE_SENS = 8'h00;
   localparam logic [7:0] CGS_RST_MODE = 8'h00;
   localparam logic [7:0] CGS_RST_DRIVE = 8'hFF;
   localparam logic [7:0] CGS_RST_OTHER = 8'h00;
   // four drive levels per output
   typedef enum logic [1:0] {
      CGS_DRV_LOW = 2'h0,
      CGS_DRV_MID_LOW = 2'h1,
      CGS_DRV_MID_HIGH = 2'h2,
      CGS_DRV_HIGH = 2'h3
   } cgs_drive_t;
   // host register bus
   localparam logic [3:0] CGS_AV_CMD = 4'h0;
   localparam logic [3:0] CGS_AV_STATUS = 4'h4;
   localparam int CGS_CMD_OP_LSB = 8;
   localparam int CGS_CMD_NACK_BIT = 10;
   localparam int CGS_STAT_ACK_BIT = 8;
   localparam int CGS_STAT_BUSY_BIT = 9;
   typedef enum logic [1:0] {
      CGS_OP_START = 2'h0,
      CGS_OP_STOP = 2'h1,
      CGS_OP_WRITE = 2'h2,
      CGS_OP_READ = 2'h3
   } cgs_op_t;
   // bus timing: clock low time sets the quarter-bit length
   localparam int CGS_MCLK_NS = 20;
   localparam int CGS_T_LOW_NS = 1300;
   localparam int CGS_QUARTER_CYC = (CGS_T_LOW_NS + 2 * CGS_MCLK_NS - 1) / (2 * CGS_MCLK_NS);

   function automatic logic [7:0] cgs_reg_default(input logic [7:0] idx);
      unique case (idx)
         CGS_REG_OE_SENS: cgs_reg_default = CGS_RST_OE_SENS;
         CGS_REG_MODE: cgs_reg_default = CGS_RST_MODE;
         CGS_REG_DRIVE_LO, CGS_REG_DRIVE_HI: cgs_reg_default = CGS_RST_DRIVE;
         default: cgs_reg_default = CGS_RST_OTHER;
      endcase
   endfunction : cgs_reg_default
endpackage : cgs_pkg

// File: include/cgs_twi_if.sv
// Purpose: wired-and two-wire link between host and slave
// Assumes: pull-ups modelled by the resolution below
// Notes: a pin is low when any party enables a low drive
`timescale 1ns/1ps
`default_nettype none
interface cgs_twi_if;
   logic h_scl_o;
   logic h_scl_oe;
   logic h_sda_o;
   logic h_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;
   assign scl = !(h_scl_oe && !h_scl_o);
   assign sda = !((h_sda_oe && !h_sda_o) || (d_sda_oe && !d_sda_o));
   modport dev (input scl, input sda, output d_sda_o, output d_sda_oe);
   modport host (input sda, output h_scl_o, output h_scl_oe, output h_sda_o, output h_sda_oe);
endinterface : cgs_twi_if
`default_nettype wire

// File: design/cgs_dev_slave.sv
// Purpose: two-wire configuration slave of the clock generator
// Assumes: scl and sda come from the link, sampled on mclk
// Notes: register storage is flip-flops; pointer wraps at 8 bits
//
// Summary of operation
// - per-output sensitivity to the output-enable pin
// - keep-alive power down keeps written registers
// - plain power down restores default registers
// - two-bit drive strength per clock output
// - registers load defaults at reset
// - serial clock up to 400 kbit/s
// - write: addr, dir, ack, reg, ack, data
// - answer bus address 69h, direction in lsb
// - data stable while clock high
// - sda fall, scl high is start
// - sda rise, scl high is stop
// - slave acks each written byte
// - master acks bytes it reads
// - master stops after single byte write
// - multi-byte write increments register address
// - read uses direction bit one
// - pointer one past last access, current read
// - repeated start after register byte sets pointer
// - master nack then stop ends transmission
// - master ack advances pointer, sends next
// - pointer wraps from ffh to 00h
`timescale 1ns/1ps
`default_nettype none
module cgs_dev_slave
   import cgs_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // two-wire link
   cgs_twi_if.dev link,
   // power-down or output-enable pin
   input wire logic powerdown_or_outen_pin,
   // controls to the clock core
   output logic pll_en,
   output logic [7:0] clk_out_en,
   output logic [15:0] drive_strength,
   output logic xfer_active
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_RX = 5'b00010,
      ST_ACK = 5'b00100,
      ST_TX = 5'b01000,
      ST_MACK = 5'b10000
   } cgs_dev_st_t;

   cgs_dev_st_t state;
   logic [1:0] scl_sy;
   logic [1:0] sda_sy;
   logic [1:0] pin_sy;
   logic scl_d;
   logic sda_d;
   logic [7:0] regs [CGS_NREG];
   logic [7:0] ptr;
   logic [7:0] sh;
   logic [3:0] cnt;
   logic [1:0] byte_idx;
   logic rw;
   logic mack;
   logic sda_o;
   logic sda_oe;
   logic scl_s;
   logic sda_s;
   logic pin_s;
   logic scl_rise;
   logic scl_fall;
   logic start_seen;
   logic stop_seen;
   logic byte_done;
   logic pd;
   logic wipe;
   logic wr_en;
   logic [7:0] mode;

   assign link.d_sda_o = sda_o;
   assign link.d_sda_oe = sda_oe;

   // two-stage synchronisers, then one delay stage for edges
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         scl_sy <= 2'h3;
         sda_sy <= 2'h3;
         pin_sy <= 2'h3;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else if (ce)
      begin
         scl_sy <= {scl_sy[0], link.scl};
         sda_sy <= {sda_sy[0], link.sda};
         pin_sy <= {pin_sy[0], powerdown_or_outen_pin};
         scl_d <= scl_sy[1];
         sda_d <= sda_sy[1];
      end
   end

   assign scl_s = scl_sy[1];
   assign sda_s = sda_sy[1];
   assign pin_s = pin_sy[1];
   assign scl_rise = scl_s && !scl_d;
   assign scl_fall = !scl_s && scl_d;
   assign start_seen = scl_s && scl_d && !sda_s && sda_d;
   assign stop_seen = scl_s && scl_d && sda_s && !sda_d;
   assign byte_done = (state == ST_RX) && scl_fall && (cnt == 4'h8);

   // power down: pin low while configured for power down
   assign mode = regs[CGS_REG_MODE];
   assign pd = !mode[CGS_MODE_OE_BIT] && !pin_s;
   // no keep-alive: registers forced to defaults
   assign wipe = pd && !mode[CGS_MODE_KEEPALIVE_BIT];
   assign wr_en = byte_done && (byte_idx == 2'h2);

   // register file
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < CGS_NREG; i++)
         begin
            regs[i] <= cgs_reg_default(8'(i));
         end
      end
      else if (ce)
      begin
         if (wipe)
         begin
            for (int i = 0; i < CGS_NREG; i++)
            begin
               regs[i] <= cgs_reg_default(8'(i));
            end
         end
         else if (wr_en)
         begin
            regs[ptr] <= sh;
         end
      end
   end

   // protocol engine
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         state <= ST_IDLE;
         ptr <= 8'h00;
         sh <= 8'h00;
         cnt <= 4'h0;
         byte_idx <= 2'h0;
         rw <= 1'b0;
         mack <= 1'b0;
         sda_o <= 1'b0;
         sda_oe <= 1'b0;
      end
      else if (ce)
      begin
         if (wipe)
         begin
            state <= ST_IDLE;
            ptr <= 8'h00;
            sda_oe <= 1'b0;
         end
         // start aborts any byte in progress
         else if (start_seen)
         begin
            state <= ST_RX;
            cnt <= 4'h0;
            byte_idx <= 2'h0;
            sda_oe <= 1'b0;
         end
         else if (stop_seen)
         begin
            state <= ST_IDLE;
            sda_oe <= 1'b0;
         end
         else
         begin
            unique case (state)
               ST_IDLE:
               begin
                  sda_oe <= 1'b0;
               end
               ST_RX:
               begin
                  if (scl_rise && cnt != 4'h8)
                  begin
                     sh <= {sh[6:0], sda_s};
                     cnt <= cnt + 4'h1;
                  end
                  else if (byte_done)
                  begin
                     // ack driven through the ninth clock
                     sda_o <= 1'b0;
                     sda_oe <= 1'b1;
                     state <= ST_ACK;
                     unique case (byte_idx)
                        2'h0:
                        begin
                           rw <= sh[0];
                           byte_idx <= 2'h1;
                           // mismatch: no ack, ignore till start
                           if (sh[7:1] != CGS_BUS_ADDR)
                           begin
                              sda_oe <= 1'b0;
                              state <= ST_IDLE;
                           end
                        end
                        2'h1:
                        begin
                           ptr <= sh;
                           byte_idx <= 2'h2;
                        end
                        default:
                        begin
                           ptr <= ptr + 8'h01;
                        end
                     endcase
                  end
               end
               ST_ACK:
               begin
                  if (scl_fall)
                  begin
                     cnt <= 4'h0;
                     if (rw && byte_idx == 2'h1)
                     begin
                        sh <= regs[ptr];
                        sda_o <= regs[ptr][7];
                        cnt <= 4'h1;
                        state <= ST_TX;
                     end
                     else
                     begin
                        sda_oe <= 1'b0;
                        state <= ST_RX;
                     end
                  end
               end
               ST_TX:
               begin
                  if (scl_fall)
                  begin
                     if (cnt != 4'h8)
                     begin
                        sda_o <= sh[6];
                        sh <= {sh[6:0], 1'b0};
                        cnt <= cnt + 4'h1;
                     end
                     else
                     begin
                        sda_oe <= 1'b0;
                        ptr <= ptr + 8'h01;
                        state <= ST_MACK;
                     end
                  end
               end
               ST_MACK:
               begin
                  if (scl_rise)
                  begin
                     mack <= !sda_s;
                  end
                  else if (scl_fall)
                  begin
                     if (mack)
                     begin
                        sh <= regs[ptr];
                        sda_o <= regs[ptr][7];
                        sda_oe <= 1'b1;
                        cnt <= 4'h1;
                        state <= ST_TX;
                     end
                     else
                     begin
                        state <= ST_IDLE;
                     end
                  end
               end
               default:
               begin
                  state <= ST_IDLE;
                  sda_oe <= 1'b0;
               end
            endcase
         end
      end
   end

   // controls to the clock core
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         pll_en <= 1'b0;
         clk_out_en <= 8'h00;
         drive_strength <= {CGS_RST_DRIVE, CGS_RST_DRIVE};
         xfer_active <= 1'b0;
      end
      else if (ce)
      begin
         // power down stops plls and outputs
         pll_en <= !pd;
         for (int i = 0; i < 8; i++)
         begin
            clk_out_en[i] <= !pd && !(mode[CGS_MODE_OE_BIT] && regs[CGS_REG_OE_SENS][i] && !pin_s);
         end
         drive_strength <= {regs[CGS_REG_DRIVE_HI], regs[CGS_REG_DRIVE_LO]};
         xfer_active <= (state != ST_IDLE);
      end
   end
endmodule : cgs_dev_slave
`default_nettype wire

// File: design/cgs_host_master.sv
// Purpose: two-wire bus master driven by byte-level commands
// Assumes: Avalon-MM slave port with waitrequest, 50 MHz mclk
// Notes: command write stalls until the engine is idle
`timescale 1ns/1ps
`default_nettype none
module cgs_host_master
   import cgs_pkg::*;
(
   // clock, reset, enable
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // two-wire link
   cgs_twi_if.host link
);
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_START = 4'b0010,
      H_BIT = 4'b0100,
      H_STOP = 4'b1000
   } cgs_host_st_t;

   cgs_host_st_t state;
   cgs_op_t op;
   logic [5:0] tick;
   logic [1:0] q;
   logic [3:0] nbit;
   logic [7:0] sh;
   logic nack;
   logic ack_seen;
   logic scl_oe;
   logic sda_oe;
   logic zero_o;
   logic [1:0] sda_sy;
   logic go;
   logic qdone;

   assign link.h_scl_o = zero_o;
   assign link.h_sda_o = zero_o;
   assign link.h_scl_oe = scl_oe;
   assign link.h_sda_oe = sda_oe;
   assign go = !avs_waitrequest && avs_write && (avs_address == CGS_AV_CMD);
   assign qdone = (tick == 6'(CGS_QUARTER_CYC - 1));

   // sda input synchroniser
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         sda_sy <= 2'h3;
      end
      else if (ce)
      begin
         sda_sy <= {sda_sy[0], link.sda};
      end
   end

   // bus slave handshake
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
      end
      else if (ce)
      begin
         if (!avs_waitrequest)
         begin
            avs_waitrequest <= 1'b1;
         end
         else if (avs_read || (avs_write && (avs_address != CGS_AV_CMD || state == H_IDLE)))
         begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= 32'h0;
            if (avs_address == CGS_AV_STATUS)
            begin
               avs_readdata <= {22'h0, state != H_IDLE, ack_seen, sh};
            end
         end
      end
   end

   // link sequencer, four quarters per bit
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         state <= H_IDLE;
         op <= CGS_OP_STOP;
         tick <= 6'h0;
         q <= 2'h0;
         nbit <= 4'h0;
         sh <= 8'h00;
         nack <= 1'b0;
         ack_seen <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         zero_o <= 1'b0;
      end
      else if (ce)
      begin
         tick <= qdone ? 6'h0 : tick + 6'h1;
         unique case (state)
            H_IDLE:
            begin
               tick <= 6'h0;
               q <= 2'h0;
               nbit <= 4'h0;
               if (go)
               begin
                  op <= cgs_op_t'(avs_writedata[CGS_CMD_OP_LSB +: 2]);
                  sh <= avs_writedata[7:0];
                  nack <= avs_writedata[CGS_CMD_NACK_BIT];
                  unique case (cgs_op_t'(avs_writedata[CGS_CMD_OP_LSB +: 2]))
                     CGS_OP_START: state <= H_START;
                     CGS_OP_STOP: state <= H_STOP;
                     default: state <= H_BIT;
                  endcase
               end
            end
            H_START:
            begin
               if (qdone)
               begin
                  q <= q + 2'h1;
                  unique case (q)
                     2'h0: sda_oe <= 1'b0;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b1;
                     default:
                     begin
                        scl_oe <= 1'b1;
                        state <= H_IDLE;
                     end
                  endcase
               end
            end
            H_STOP:
            begin
               if (qdone)
               begin
                  q <= q + 2'h1;
                  unique case (q)
                     2'h0: sda_oe <= 1'b1;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     default: state <= H_IDLE;
                  endcase
               end
            end
            H_BIT:
            begin
               if (qdone)
               begin
                  q <= q + 2'h1;
                  unique case (q)
                     2'h0:
                     begin
                        if (nbit == 4'h8)
                        begin
                           sda_oe <= (op == CGS_OP_READ) && !nack;
                        end
                        else
                        begin
                           sda_oe <= (op == CGS_OP_WRITE) && !sh[7];
                        end
                     end
                     2'h1: scl_oe <= 1'b0;
                     2'h2:
                     begin
                        if (nbit == 4'h8)
                        begin
                           ack_seen <= !sda_sy[1];
                        end
                        else
                        begin
                           sh <= {sh[6:0], sda_sy[1]};
                        end
                     end
                     default:
                     begin
                        scl_oe <= 1'b1;
                        nbit <= nbit + 4'h1;
                        if (nbit == 4'h8)
                        begin
                           sda_oe <= 1'b0;
                           state <= H_IDLE;
                        end
                     end
                  endcase
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
endmodule : cgs_host_master
`default_nettype wire

// File: sim/cgs_twi_assertions.sv
// Purpose: wire checks of the slave's drive on the two-wire link
// Assumes: one mclk domain, scl and sda already resolved
// Notes: byte position is tracked from scl edges seen on mclk
`timescale 1ns/1ps
`default_nettype none
module cgs_twi_assertions
   import cgs_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rstn,
   // link signals
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic scl,
   input wire logic sda
);
   logic scl_q, sda_q, adr_ok, rd;
   logic [3:0] bitn;
   logic [7:0] sh, nbyte;
   wire logic rise = scl && !scl_q;
   wire logic fall = !scl && scl_q;
   wire logic strt = scl && scl_q && sda_q && !sda;
   wire logic stp = scl && scl_q && !sda_q && sda;
   wire logic drv = d_sda_oe && !d_sda_o;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rstn);
   // previous line levels
   always_ff @(posedge mclk)
   begin
      scl_q <= !rstn || scl;
      sda_q <= !rstn || sda;
   end
   // bit, byte and direction tracking
   always_ff @(posedge mclk)
   begin
      if (!rstn || strt)
      begin
         bitn <= 4'h0;
         nbyte <= 8'h00;
         adr_ok <= 1'b0;
         rd <= 1'b0;
      end
      else if (rise)
      begin
         bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
         if (bitn == 4'h8 && nbyte != 8'hFF)
            nbyte <= nbyte + 8'h01;
         if (bitn == 4'h7 && nbyte == 8'h00)
         begin
            adr_ok <= (sh[6:0] == CGS_BUS_ADDR);
            rd <= sda;
         end
      end
   end
   always_ff @(posedge mclk)
   begin
      if (rise)
         sh <= {sh[6:0], sda};
   end
   a_addr_ack: assert property (rise && bitn == 4'h8 && nbyte == 8'h00 && adr_ok |-> drv)
      else $error("own address not acknowledged");
   a_miss_silent: assert property (rise && bitn == 4'h8 && nbyte == 8'h00 && !adr_ok |-> !d_sda_oe)
      else $error("foreign address driven");
   a_data_ack: assert property (rise && bitn == 4'h8 && nbyte != 8'h00 && adr_ok && !rd |-> drv)
      else $error("written byte not acknowledged");
   a_read_drive: assert property (rise && bitn != 4'h0 && bitn < 4'h8 && nbyte != 8'h00
      && rd && adr_ok |-> d_sda_oe)
      else $error("read bit not driven");
   a_read_release: assert property (rise && bitn == 4'h8 && nbyte != 8'h00 && rd |-> !d_sda_oe)
      else $error("slave drives the master ack");
   a_stable_high: assert property (scl && $past(scl) |-> $stable(drv))
      else $error("slave drive moved while scl high");
   a_stop_release: assert property (stp |-> !d_sda_oe [*8])
      else $error("line held after stop");
   a_ack_release: assert property (fall && bitn == 4'h9 && adr_ok && !rd |-> ##[1:8] !d_sda_oe)
      else $error("ack not released");
   c_seq_read: cover property (rise && bitn == 4'h8 && nbyte == 8'h03 && rd);
   c_miss: cover property (rise && bitn == 4'h8 && nbyte == 8'h00 && !adr_ok);
   c_restart: cover property (strt && nbyte != 8'h00);
endmodule : cgs_twi_assertions
`default_nettype wire

// File: sim/clockgen_two_wire_config_slave_tb.sv
// Purpose: drives the host master over its register bus against the slave
// Assumes: both ends on one 50 MHz mclk, joined by cgs_twi_if
// Notes: each test is a sequence of byte-level link commands
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED at %0t: got %h exp %h", $time, g, e); end end
module clockgen_two_wire_config_slave_tb
   import cgs_pkg::*;
;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic powerdown_or_outen_pin = 1'b1;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata, st;
   logic avs_waitrequest, pll_en, xfer_active;
   logic [7:0] clk_out_en;
   logic [15:0] drive_strength;
   int errors = 0;
   int n_compared = 0;
   always #10 mclk = ~mclk;
   cgs_twi_if link ();
   cgs_dev_slave i_cgs_dev_slave (.mclk(mclk), .rstn(rstn), .ce(1'b1), .link(link),
      .powerdown_or_outen_pin(powerdown_or_outen_pin), .pll_en(pll_en),
      .clk_out_en(clk_out_en), .drive_strength(drive_strength), .xfer_active(xfer_active));
   cgs_host_master i_cgs_host_master (.mclk(mclk), .rstn(rstn), .ce(1'b1),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .link(link));
   cgs_twi_assertions i_cgs_twi_assertions (.mclk(mclk), .rstn(rstn), .d_sda_o(link.d_sda_o),
      .d_sda_oe(link.d_sda_oe), .scl(link.scl), .sda(link.sda));

   task automatic report_and_stop;
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : report_and_stop

   task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 5000);
      st = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (avs_waitrequest !== 1'b0)
      begin
         errors++;
         report_and_stop();
      end
      @(posedge mclk);
   endtask : av

   task automatic op(input cgs_op_t c, input logic [7:0] b, input logic nk);
      int n;
      n = 0;
      av(1'b1, CGS_AV_CMD, {21'h0, nk, c, b});
      do
      begin
         av(1'b0, CGS_AV_STATUS, 32'h0);
         n++;
      end
      while (st[CGS_STAT_BUSY_BIT] !== 1'b0 && n < 2000);
      if (st[CGS_STAT_BUSY_BIT] !== 1'b0)
      begin
         errors++;
         report_and_stop();
      end
   endtask : op

   task automatic wr_regs(input logic [7:0] ra, input logic [7:0] d[$]);
      op(CGS_OP_START, 8'h00, 1'b0);
      op(CGS_OP_WRITE, {CGS_BUS_ADDR, 1'b0}, 1'b0);
      `CHK(st[CGS_STAT_ACK_BIT], 1'b1) // address ack
      op(CGS_OP_WRITE, ra, 1'b0);
      `CHK(st[CGS_STAT_ACK_BIT], 1'b1) // register byte ack
      foreach (d[i])
      begin
         op(CGS_OP_WRITE, d[i], 1'b0);
         `CHK(st[CGS_STAT_ACK_BIT], 1'b1) // data ack
      end
      op(CGS_OP_STOP, 8'h00, 1'b0);
      `CHK(xfer_active, 1'b0) // stop ends transfer
   endtask : wr_regs

   task automatic rd_regs(input logic rnd, input logic [7:0] ra, input logic [7:0] e[$]);
      op(CGS_OP_START, 8'h00, 1'b0);
      if (rnd)
      begin
         op(CGS_OP_WRITE, {CGS_BUS_ADDR, 1'b0}, 1'b0);
         op(CGS_OP_WRITE, ra, 1'b0);
         op(CGS_OP_START, 8'h00, 1'b0);
      end
      op(CGS_OP_WRITE, {CGS_BUS_ADDR, 1'b1}, 1'b0);
      `CHK(st[CGS_STAT_ACK_BIT], 1'b1) // read address ack
      foreach (e[i])
      begin
         op(CGS_OP_READ, 8'h00, i == e.size() - 1);
         `CHK(st[7:0], e[i]) // byte at pointer
      end
      op(CGS_OP_STOP, 8'h00, 1'b0);
   endtask : rd_regs

   task automatic pd_pulse;
      powerdown_or_outen_pin <= 1'b0;
      repeat (8) @(posedge mclk);
      `CHK(pll_en, 1'b0) // plls off
      `CHK(clk_out_en, 8'h00) // outputs off
      powerdown_or_outen_pin <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask : pd_pulse

   initial
   begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      `CHK(drive_strength, 16'hFFFF) // default drive
      rd_regs(1'b1, 8'h00, {CGS_RST_OE_SENS, CGS_RST_MODE, CGS_RST_DRIVE, CGS_RST_DRIVE});
      $display("test defaults done");
      wr_regs(CGS_REG_DRIVE_LO, {8'h1B, 8'hE4}); // auto increment
      `CHK(drive_strength, 16'hE41B) // drive field
      for (int k = 0; k < 4; k++)
         `CHK(drive_strength[2*k +: 2], cgs_drive_t'(3 - k)) // each level
      wr_regs(8'h20, {8'h5A, 8'hC3});
      rd_regs(1'b1, 8'h20, {8'h5A}); // random read
      rd_regs(1'b0, 8'h00, {8'hC3}); // current address
      $display("test write and read done");
      wr_regs(8'hFF, {8'h11, 8'h22, 8'h02}); // write wraps
      rd_regs(1'b1, 8'hFF, {8'h11, 8'h22, 8'h02}); // read wraps
      powerdown_or_outen_pin <= 1'b0;
      repeat (8) @(posedge mclk);
      `CHK(clk_out_en, ~8'h22) // sensitive outputs off
      `CHK(pll_en, 1'b1) // plls stay on
      powerdown_or_outen_pin <= 1'b1;
      repeat (8) @(posedge mclk);
      `CHK(clk_out_en, 8'hFF) // outputs back on
      $display("test wrap and enable done");
      op(CGS_OP_START, 8'h00, 1'b0);
      `CHK(xfer_active, 1'b1) // transfer open
      op(CGS_OP_WRITE, {CGS_BUS_ADDR ^ 7'h01, 1'b0}, 1'b0);
      `CHK(st[CGS_STAT_ACK_BIT], 1'b0) // no ack
      `CHK(xfer_active, 1'b0) // rest ignored
      op(CGS_OP_WRITE, 8'h20, 1'b0);
      op(CGS_OP_WRITE, 8'h77, 1'b0);
      op(CGS_OP_STOP, 8'h00, 1'b0);
      rd_regs(1'b1, 8'h20, {8'h5A}); // register untouched
      $display("test foreign address done");
      wr_regs(CGS_REG_MODE, {8'h01});
      pd_pulse();
      rd_regs(1'b1, 8'h00, {8'h22, 8'h01, 8'h1B}); // values kept
      wr_regs(CGS_REG_MODE, {8'h00});
      pd_pulse();
      rd_regs(1'b1, 8'h00, {CGS_RST_OE_SENS, CGS_RST_MODE, CGS_RST_DRIVE}); // defaults back
      `CHK(drive_strength, 16'hFFFF) // default drive
      $display("test power down done");
      report_and_stop();
   end
endmodule : clockgen_two_wire_config_slave_tb
`default_nettype wire
